// ### ptm_pkg.sv
package ptm_pkg;
    localparam int PTM_NUM_CHAN = 3;
    // byte offsets of the host port
    localparam logic [7:0] PTM_OFS_CNT0 = 8'h24;
    localparam logic [7:0] PTM_OFS_CNT1 = 8'h25;
    localparam logic [7:0] PTM_OFS_CNT2 = 8'h26;
    localparam logic [7:0] PTM_OFS_CTRL = 8'h27;
    // control word fields
    localparam int PTM_SEL_LO = 6;
    localparam int PTM_ACC_LO = 4;
    localparam int PTM_MODE_LO = 1;
    localparam int PTM_BCD_POS = 0;
    localparam int PTM_RB_CNT_N = 5;
    localparam int PTM_RB_FLAGS_N = 4;
    localparam int PTM_RB_PICK_LO = 1;
    localparam logic [1:0] PTM_SEL_READBACK = 2'h3;
    localparam logic [1:0] PTM_ACC_LATCH = 2'h0;
    localparam logic [1:0] PTM_ACC_LSB = 2'h1;
    localparam logic [1:0] PTM_ACC_MSB = 2'h2;
    localparam logic [1:0] PTM_ACC_WORD = 2'h3;
    // reset values, then the count constants one and two
    localparam logic [5:0] PTM_RST_CTL = 6'h00;
    localparam logic [15:0] PTM_RST_COUNT = 16'h0000;
    localparam logic [7:0] PTM_RST_BYTE = 8'h00;
    localparam logic PTM_RST_OUT = 1'b0;
    localparam logic [15:0] PTM_ONE = 16'h0001;
    localparam logic [15:0] PTM_TWO = 16'h0002;
    typedef enum {PTM_M0, PTM_M1, PTM_M2, PTM_M3, PTM_M4, PTM_M5} ptm_mode_t;
endpackage

// ### ptm_timer_port.sv
// Behaviour
// - counter data ports at 0x24..0x26 read/write; control word at 0x27.
// - control word: select 7:6, access 5:4, mode 3:1, bcd bit 0.
// - select 0,1,2 picks a counter; 3 means readback command.
// - access 0 latch, 1 low byte, 2 high byte, 3 low then high.
// - mode codes 000..101; top bit ignored for modes 2 and 3.
// - bcd bit clear counts binary, set counts decimal.
// - latch copies count into hold register; later reads return it.
// - two-byte mode alternates low then high via a toggle.
// - readback: 11, count latch_n, flags latch_n, picks 2..0, zero.
// - readback with count latch low latches all picked counters together.
// - readback with flags latch low captures status; next read returns it.
// - status: out, null count, access, mode, bcd.
// - null count set from count write until moved into counter.
// - status then latched low byte then latched high byte.
// - further count latches ignored until held value is read.
// - status latched over an unread count is read first.
// - mode 0 out low after load, high at zero until reload.
// - mode 1 out low after gate rise, high at zero, retriggerable.
// - mode 2 out low one clock every N counts, reloads.
// - mode 3 square wave, odd N high (N+1)/2, low (N-1)/2.
`timescale 1ns/1ns
`default_nettype none
module ptm_timer_port
    import ptm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic [2:0] cnt_clk,
    input wire logic [2:0] cnt_gate,
    output logic [2:0] cnt_out
);
    function automatic logic [15:0] ptm_dec(input logic [15:0] v,
                                            input logic bcd);
        logic [15:0] r;
        logic b;
        r = v;
        b = 1'b1;
        if (!bcd) begin
            r = v - PTM_ONE;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (b) begin
                    if (r[4*i+:4] == 4'h0) begin
                        r[4*i+:4] = 4'h9;
                    end else begin
                        r[4*i+:4] = r[4*i+:4] - 4'h1;
                        b = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    logic wr_ctrl;
    logic [2:0] wr_port;
    logic [2:0] rd_port;
    logic rb_cmd;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb begin
        wr_ctrl = wr_stb && addr == PTM_OFS_CTRL;
        wr_port = 3'h0;
        rd_port = 3'h0;
        if (addr == PTM_OFS_CNT0) begin
            wr_port[0] = wr_stb;
            rd_port[0] = rd_stb;
        end else if (addr == PTM_OFS_CNT1) begin
            wr_port[1] = wr_stb;
            rd_port[1] = rd_stb;
        end else if (addr == PTM_OFS_CNT2) begin
            wr_port[2] = wr_stb;
            rd_port[2] = rd_stb;
        end
        rb_cmd = wdata[PTM_SEL_LO+:2] == PTM_SEL_READBACK;
    end

    genvar ch;
    generate
        for (ch = 0; ch < PTM_NUM_CHAN; ch++) begin : chan
            logic [5:0] ctl_reg, ctl_next;
            logic [15:0] init_reg, init_next;
            logic [15:0] ce_reg, ce_next;
            logic [15:0] hold_reg, hold_next;
            logic [7:0] stat_reg, stat_next;
            logic held_reg, held_next;
            logic statv_reg, statv_next;
            logic rtog_reg, rtog_next;
            logic wtog_reg, wtog_next;
            logic null_reg, null_next;
            logic out_reg, out_next;
            logic pend_reg, pend_next;
            logic trig_reg, trig_next;
            logic armed_reg, armed_next;
            logic gprev_reg, cprev_reg;
            // first stages feed only the second stages
            logic c_s1_reg, c_s2_reg, g_s1_reg, g_s2_reg;
            logic [7:0] rdb;
            logic [15:0] val;
            logic rd_done;
            logic loaded;
            logic clk_rise;
            ptm_mode_t md;

            always_comb begin
                ctl_next = ctl_reg;
                init_next = init_reg;
                ce_next = ce_reg;
                hold_next = hold_reg;
                stat_next = stat_reg;
                held_next = held_reg;
                statv_next = statv_reg;
                rtog_next = rtog_reg;
                wtog_next = wtog_reg;
                null_next = null_reg;
                out_next = out_reg;
                pend_next = pend_reg;
                trig_next = trig_reg | (g_s2_reg & ~gprev_reg);
                armed_next = armed_reg;
                clk_rise = c_s2_reg & ~cprev_reg;
                loaded = 1'b0;
                rd_done = 1'b0;
                case (ctl_reg[PTM_MODE_LO+:3])
                    3'h0: md = PTM_M0;
                    3'h1: md = PTM_M1;
                    3'h4: md = PTM_M4;
                    3'h5: md = PTM_M5;
                    default: md = ctl_reg[PTM_MODE_LO] ? PTM_M3 : PTM_M2;
                endcase
                // count down on a synced clock rise when the gate and mode allow
                if (clk_rise) begin
                    trig_next = 1'b0;
                    case (md)
                        PTM_M0: begin
                            if (pend_reg) begin
                                ce_next = init_reg;
                                null_next = 1'b0;
                                pend_next = 1'b0;
                            end else if (g_s2_reg) begin
                                ce_next = ptm_dec(ce_reg, ctl_reg[0]);
                                if (ce_reg == PTM_ONE) begin
                                    out_next = 1'b1;
                                end
                            end
                        end
                        PTM_M1, PTM_M5: begin
                            out_next = (md == PTM_M1) ? out_reg : 1'b1;
                            if (trig_reg) begin
                                ce_next = init_reg;
                                null_next = 1'b0;
                                armed_next = 1'b1;
                                out_next = md != PTM_M1;
                            end else if (armed_reg) begin
                                ce_next = ptm_dec(ce_reg, ctl_reg[0]);
                                if (ce_reg == PTM_ONE) begin
                                    out_next = md == PTM_M1;
                                    armed_next = 1'b0;
                                end
                            end
                            pend_next = 1'b0;
                        end
                        PTM_M2: begin
                            if (!g_s2_reg) begin
                                out_next = 1'b1;
                            end else if (pend_reg || trig_reg ||
                                         ce_reg == PTM_ONE) begin
                                ce_next = init_reg;
                                null_next = 1'b0;
                                pend_next = 1'b0;
                                out_next = 1'b1;
                            end else begin
                                ce_next = ptm_dec(ce_reg, ctl_reg[0]);
                                out_next = ce_reg != PTM_TWO;
                            end
                        end
                        PTM_M3: begin
                            // odd counts add one on the high half and
                            // drop one on the low half
                            if (!g_s2_reg) begin
                                out_next = 1'b1;
                            end else if (pend_reg || trig_reg) begin
                                out_next = 1'b1;
                                ce_next = init_reg + {15'h0000, init_reg[0]};
                                null_next = 1'b0;
                                pend_next = 1'b0;
                            end else if (ce_reg <= PTM_TWO) begin
                                out_next = ~out_reg;
                                ce_next = out_reg ?
                                    init_reg - {15'h0000, init_reg[0]} :
                                    init_reg + {15'h0000, init_reg[0]};
                            end else begin
                                ce_next = ptm_dec(ptm_dec(ce_reg,
                                    ctl_reg[0]), ctl_reg[0]);
                            end
                        end
                        default: begin
                            out_next = 1'b1;
                            if (pend_reg) begin
                                ce_next = init_reg;
                                null_next = 1'b0;
                                pend_next = 1'b0;
                                armed_next = 1'b1;
                            end else if (g_s2_reg && armed_reg) begin
                                ce_next = ptm_dec(ce_reg, ctl_reg[0]);
                                if (ce_reg == PTM_ONE) begin
                                    out_next = 1'b0;
                                    armed_next = 1'b0;
                                end
                            end
                        end
                    endcase
                end
                // read path: status first, then held or live count
                val = held_reg ? hold_reg : ce_reg;
                if (statv_reg) begin
                    rdb = stat_reg;
                end else if (ctl_reg[PTM_ACC_LO+:2] == PTM_ACC_MSB) begin
                    rdb = val[15:8];
                    rd_done = 1'b1;
                end else if (ctl_reg[PTM_ACC_LO+:2] == PTM_ACC_WORD &&
                             rtog_reg) begin
                    rdb = val[15:8];
                    rd_done = 1'b1;
                end else begin
                    rdb = val[7:0];
                    rd_done = ctl_reg[PTM_ACC_LO+:2] != PTM_ACC_WORD;
                end
                if (rd_port[ch]) begin
                    if (statv_reg) begin
                        statv_next = 1'b0;
                    end else if (rd_done) begin
                        rtog_next = 1'b0;
                        held_next = 1'b0;
                    end else begin
                        rtog_next = 1'b1;
                    end
                end
                // host writes of the count
                if (wr_port[ch]) begin
                    case (ctl_reg[PTM_ACC_LO+:2])
                        PTM_ACC_LSB: begin
                            init_next = {8'h00, wdata};
                            loaded = 1'b1;
                        end
                        PTM_ACC_MSB: begin
                            init_next = {wdata, 8'h00};
                            loaded = 1'b1;
                        end
                        default: begin
                            if (!wtog_reg) begin
                                init_next[7:0] = wdata;
                                wtog_next = 1'b1;
                            end else begin
                                init_next[15:8] = wdata;
                                wtog_next = 1'b0;
                                loaded = 1'b1;
                            end
                        end
                    endcase
                    if (loaded) begin
                        null_next = 1'b1;
                        // gate edges from before the load must not fire it
                        trig_next = g_s2_reg & ~gprev_reg;
                        pend_next = 1'b1;
                        armed_next = 1'b0;
                        out_next = md != PTM_M0;
                    end
                end
                // control words: only this counter is touched
                if (wr_ctrl && rb_cmd && wdata[PTM_RB_PICK_LO+ch]) begin
                    if (!wdata[PTM_RB_CNT_N] && !held_next) begin
                        hold_next = ce_reg;
                        held_next = 1'b1;
                    end
                    if (!wdata[PTM_RB_FLAGS_N] && !statv_next) begin
                        stat_next = {out_reg, null_reg, ctl_reg};
                        statv_next = 1'b1;
                    end
                end else if (wr_ctrl && !rb_cmd &&
                             wdata[PTM_SEL_LO+:2] == 2'(ch)) begin
                    if (wdata[PTM_ACC_LO+:2] == PTM_ACC_LATCH) begin
                        if (!held_next) begin
                            hold_next = ce_reg;
                            held_next = 1'b1;
                        end
                    end else begin
                        ctl_next = wdata[5:0];
                        out_next = wdata[PTM_MODE_LO+:3] != 3'h0;
                        null_next = 1'b1;
                        pend_next = 1'b0;
                        armed_next = 1'b0;
                        wtog_next = 1'b0;
                        rtog_next = 1'b0;
                        held_next = 1'b0;
                        statv_next = 1'b0;
                    end
                end
            end

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    ctl_reg <= PTM_RST_CTL;
                    init_reg <= PTM_RST_COUNT;
                    ce_reg <= PTM_RST_COUNT;
                    hold_reg <= PTM_RST_COUNT;
                    stat_reg <= PTM_RST_BYTE;
                    held_reg <= 1'b0;
                    statv_reg <= 1'b0;
                    rtog_reg <= 1'b0;
                    wtog_reg <= 1'b0;
                    null_reg <= 1'b0;
                    out_reg <= PTM_RST_OUT;
                    pend_reg <= 1'b0;
                    trig_reg <= 1'b0;
                    armed_reg <= 1'b0;
                    gprev_reg <= 1'b0;
                    cprev_reg <= 1'b0;
                    c_s1_reg <= 1'b0;
                    c_s2_reg <= 1'b0;
                    g_s1_reg <= 1'b0;
                    g_s2_reg <= 1'b0;
                end else begin
                    ctl_reg <= ctl_next;
                    init_reg <= init_next;
                    ce_reg <= ce_next;
                    hold_reg <= hold_next;
                    stat_reg <= stat_next;
                    held_reg <= held_next;
                    statv_reg <= statv_next;
                    rtog_reg <= rtog_next;
                    wtog_reg <= wtog_next;
                    null_reg <= null_next;
                    out_reg <= out_next;
                    pend_reg <= pend_next;
                    trig_reg <= trig_next;
                    armed_reg <= armed_next;
                    gprev_reg <= g_s2_reg;
                    cprev_reg <= c_s2_reg;
                    c_s1_reg <= cnt_clk[ch];
                    c_s2_reg <= c_s1_reg;
                    g_s1_reg <= cnt_gate[ch];
                    g_s2_reg <= g_s1_reg;
                end
            end

            assign cnt_out[ch] = out_reg;
        end
    endgenerate

    always_comb begin
        rdata_next = rdata_reg;
        if (rd_port[0]) begin
            rdata_next = chan[0].rdb;
        end else if (rd_port[1]) begin
            rdata_next = chan[1].rdb;
        end else if (rd_port[2]) begin
            rdata_next = chan[2].rdb;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_reg <= PTM_RST_BYTE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
endmodule
`default_nettype wire

// ### ptm_host.sv
`timescale 1ns/1ns
`default_nettype none
module ptm_host (
    input wire logic mclk,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic wr_stb,
    output logic rd_stb,
    output logic [7:0] wdata
);
    initial begin
        addr = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        wdata = 8'h00;
    end
    // one byte per call; callers keep two-byte loads low then high
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        wdata <= ~d;
    endtask
    // running counts are latched first, never read raw
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ### ptm_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ptm_chk
    import ptm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic [2:0] cnt_clk,
    input wire logic [2:0] cnt_gate,
    input wire logic [2:0] cnt_out
);
    // cycles since a pin edge or host write; sync delay is well under 8
    logic [3:0] quiet_reg [3];
    logic [3:0] quiet_next [3];
    logic [2:0] pin_reg;
    logic [2:0] pin_next;
    logic [2:0] gate_reg;
    logic [2:0] gate_next;
    always_comb begin
        pin_next = cnt_clk;
        gate_next = cnt_gate;
        for (int i = 0; i < 3; i++) begin
            quiet_next[i] = quiet_reg[i];
            if (quiet_reg[i] != 4'hf)
                quiet_next[i] = quiet_reg[i] + 4'h1;
            if (cnt_clk[i] != pin_reg[i] || cnt_gate[i] != gate_reg[i] ||
                wr_stb)
                quiet_next[i] = 4'h0;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_reg <= 3'h0;
            gate_reg <= 3'h0;
            for (int i = 0; i < 3; i++)
                quiet_reg[i] <= 4'h0;
        end else begin
            pin_reg <= pin_next;
            gate_reg <= gate_next;
            for (int i = 0; i < 3; i++)
                quiet_reg[i] <= quiet_next[i];
        end
    end
    a_read_only_moves: assert property (
        @(posedge mclk) disable iff (rst) $changed(rdata) |-> $past(rd_stb))
        else $error("rdata moved without read");
    a_unmapped_ignored: assert property (
        @(posedge mclk) disable iff (rst)
        rd_stb && (addr < PTM_OFS_CNT0 || addr > PTM_OFS_CTRL)
        |=> $stable(rdata))
        else $error("unmapped read changed rdata");
    a_ctrl_not_read: assert property (
        @(posedge mclk) disable iff (rst)
        rd_stb && addr == PTM_OFS_CTRL |=> $stable(rdata))
        else $error("control word read changed rdata");
    a_write_no_read: assert property (
        @(posedge mclk) disable iff (rst)
        wr_stb && !rd_stb |=> $stable(rdata))
        else $error("write changed rdata");
    a_reset_clear: assert property (@(posedge mclk)
        rst |=> rdata == 8'h00 && cnt_out == 3'h0)
        else $error("reset not clean");
    a_quiet_out_zero: assert property (
        @(posedge mclk) disable iff (rst)
        quiet_reg[0] >= 4'h8 |-> $stable(cnt_out[0]))
        else $error("out0 moved");
    a_quiet_out_one: assert property (
        @(posedge mclk) disable iff (rst)
        quiet_reg[1] >= 4'h8 |-> $stable(cnt_out[1]))
        else $error("out1 moved");
    a_quiet_out_two: assert property (
        @(posedge mclk) disable iff (rst)
        quiet_reg[2] >= 4'h8 |-> $stable(cnt_out[2]))
        else $error("out2 moved");
    c_readback: cover property (@(posedge mclk)
        wr_stb && addr == PTM_OFS_CTRL && wdata[7:6] == PTM_SEL_READBACK);
    c_latch: cover property (@(posedge mclk) wr_stb && addr == PTM_OFS_CTRL
        && wdata[7:6] != PTM_SEL_READBACK && wdata[5:4] == PTM_ACC_LATCH);
    c_out_rise: cover property (@(posedge mclk) $rose(cnt_out[0]));
endmodule
bind ptm_timer_port ptm_chk u_chk (.mclk(mclk), .rst(rst), .addr(addr),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .wdata(wdata), .rdata(rdata),
    .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out));
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ptm_pkg::*;
    logic mclk, rst, wr_stb, rd_stb;
    logic [7:0] addr, wdata, rdata, v, c;
    logic [2:0] cnt_clk, cnt_gate, cnt_out;
    int fail_count = 0;
    int compares = 0;
    ptm_host host (.mclk(mclk), .rdata(rdata), .addr(addr),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .wdata(wdata));
    ptm_timer_port dut (.mclk(mclk), .rst(rst), .addr(addr), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .wdata(wdata), .rdata(rdata), .cnt_clk(cnt_clk),
        .cnt_gate(cnt_gate), .cnt_out(cnt_out));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic results;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmp_pin(input string what, input logic seen,
        input logic exp);
        cmp(what, {7'h00, seen}, {7'h00, exp});
    endtask
    task automatic rd_pair(input logic [7:0] a, input logic [15:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        cmp("count low byte", d, exp[7:0]);
        host.rd(a, d);
        cmp("count high byte", d, exp[15:8]);
    endtask
    // pin clock kept well under a quarter of mclk so no edge is lost
    task automatic tick(input int ch, input int n);
        repeat (n) begin
            @(posedge mclk) cnt_clk[ch] <= 1'b1;
            repeat (4) @(posedge mclk);
            cnt_clk[ch] <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        @(negedge mclk);
    endtask
    initial begin
        #200000;
        fail_count++;
        results();
    end
    initial begin
        rst = 1'b1;
        cnt_clk = 3'h0;
        cnt_gate = 3'h0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        cnt_gate <= 3'h7;
        @(negedge mclk);
        cmp("rdata after reset", rdata, 8'h00);
        host.wr(PTM_OFS_CTRL, 8'h30);
        host.wr(PTM_OFS_CNT0, 8'h03);
        host.wr(PTM_OFS_CNT0, 8'h00);
        host.wr(PTM_OFS_CTRL, 8'he2);
        host.rd(PTM_OFS_CNT0, v);
        cmp("status0 pending", v, 8'h70);
        tick(0, 3);
        cmp_pin("out0 counting", cnt_out[0], 1'b0);
        tick(0, 1);
        cmp_pin("out0 at zero", cnt_out[0], 1'b1);
        host.wr(PTM_OFS_CTRL, 8'he2);
        host.rd(PTM_OFS_CNT0, v);
        cmp("status0 done", v, 8'hb0);
        host.wr(PTM_OFS_CTRL, 8'h74);
        host.wr(PTM_OFS_CNT1, 8'h10);
        host.wr(PTM_OFS_CNT1, 8'h00);
        tick(1, 3);
        host.wr(PTM_OFS_CTRL, 8'h40);
        tick(1, 2);
        host.wr(PTM_OFS_CTRL, 8'h40);
        rd_pair(PTM_OFS_CNT1, 16'h000e);
        host.wr(PTM_OFS_CTRL, 8'hd4);
        rd_pair(PTM_OFS_CNT1, 16'h000c);
        host.wr(PTM_OFS_CTRL, 8'h40);
        host.wr(PTM_OFS_CTRL, 8'he4);
        host.rd(PTM_OFS_CNT1, v);
        cmp("status1 first", v, 8'hb4);
        rd_pair(PTM_OFS_CNT1, 16'h000c);
        host.rd(8'h30, v);
        cmp("unmapped read", v, 8'h00);
        host.rd(PTM_OFS_CTRL, v);
        cmp("control read", v, 8'h00);
        for (int m = 0; m < 6; m++) begin
            for (int b = 0; b < 2; b++) begin
                c = {2'b10, PTM_ACC_LSB, m[2:0], b[0]};
                host.wr(PTM_OFS_CTRL, c);
                host.wr(PTM_OFS_CTRL, 8'he8);
                host.rd(PTM_OFS_CNT2, v);
                cmp("status2 fields", v & 8'h3f, c & 8'h3f);
            end
        end
        host.wr(PTM_OFS_CTRL, 8'h40);
        rd_pair(PTM_OFS_CNT1, 16'h000c);
        host.wr(PTM_OFS_CTRL, 8'h9c);
        host.wr(PTM_OFS_CNT2, 8'h03);
        tick(2, 2);
        cmp_pin("out2 rate high", cnt_out[2], 1'b1);
        tick(2, 1);
        cmp_pin("out2 rate low", cnt_out[2], 1'b0);
        tick(2, 1);
        cmp_pin("out2 rate reload", cnt_out[2], 1'b1);
        host.wr(PTM_OFS_CTRL, 8'h96);
        host.wr(PTM_OFS_CNT2, 8'h05);
        tick(2, 3);
        cmp_pin("out2 square high", cnt_out[2], 1'b1);
        tick(2, 1);
        cmp_pin("out2 square low", cnt_out[2], 1'b0);
        tick(2, 1);
        cmp_pin("out2 square low", cnt_out[2], 1'b0);
        tick(2, 1);
        cmp_pin("out2 square back", cnt_out[2], 1'b1);
        host.wr(PTM_OFS_CTRL, 8'h92);
        host.wr(PTM_OFS_CNT2, 8'h02);
        tick(2, 1);
        cmp_pin("out2 no trigger", cnt_out[2], 1'b1);
        @(posedge mclk) cnt_gate[2] <= 1'b0;
        repeat (4) @(posedge mclk);
        cnt_gate[2] <= 1'b1;
        repeat (4) @(posedge mclk);
        tick(2, 1);
        cmp_pin("out2 shot low", cnt_out[2], 1'b0);
        tick(2, 2);
        cmp_pin("out2 shot end", cnt_out[2], 1'b1);
        results();
    end
endmodule
`default_nettype wire
